/* File: verilog/port_pin_defs.vh */
// Constants for the two-port pin logic block.
// Assumes inclusion by the single design file only.
`ifndef PORT_PIN_DEFS_VH
`define PORT_PIN_DEFS_VH

`define PORT_WIDTH 8
`define LATCH_RESET 8'hFF
`define INMODE_RESET 8'hFF
`define ADDR_WIDTH 24
`define LOW_BYTE_LSB 0
`define PAGE_BYTE_LSB 16
`define CHSEL_WIDTH 3
`define CHSEL_ZERO 3'h0
`define ALE_CYCLES 2'h1
// Three data cycles: a read is sampled through the two-flop synchroniser,
// so the pins must carry the data two edges before the sample
`define DATA_CYCLES 2'h3
`define CNT_LAST 2'h1
`define CNT_STEP 2'h1
`define CNT_CLEAR 2'h0
`define BYTE_CLEAR 8'h00
`define ADDR_CLEAR 24'h000000
`define SYNC_RESET 8'h00
`define DRIVE_ALL 8'hFF
`define DRIVE_NONE 8'h00
`define FLAG_CLEAR 1'b0
`define EDGE_RESET 1'b0
`define COUNT_PIN_BIT 0

`endif

/* File: verilog/port_pin_logic.v */
// Pin logic of the open-drain multiplexed port and the input-only port.
// Assumes the core supplies latch writes, bus requests and channel select
// on MCLK; pin inputs arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
`include "port_pin_defs.vh"

// What this block does
// - Open-drain pins driven low when latch zero
// - Latch one leaves pin floating for input
// - Bus carries low address then data byte
// - Bus drives ones high actively
// - Second port is input only
// - Second port resets to analog mode
// - Writing zero selects digital; read returns level
// - Pin zero is ADC input, channel selectable
// - Counter two counts pin zero falling edges
// - Strobe latches low address byte; page byte held on PAGE_OUT
module port_pin_logic (
  // Clock, reset, enable
  input wire MCLK,
  input wire RESET_N,
  input wire CLK_EN,
  // Port latch writes from the core
  input wire LATCH_WR,
  input wire [7:0] LATCH_WDATA,
  // Input port mode writes
  input wire INMODE_WR,
  input wire [7:0] INMODE_WDATA,
  // External data memory request
  input wire XMEM_REQ,
  input wire XMEM_WRITE,
  input wire [23:0] XMEM_ADDR,
  input wire [7:0] XMEM_WDATA,
  // ADC channel select and counter enable
  input wire [2:0] ADC_CHSEL,
  input wire CNT_EXT_EN,
  // Open-drain bidirectional pins
  input wire [7:0] BIDIR_PIN_IN,
  output reg [7:0] BIDIR_PIN_OUT,
  output reg [7:0] BIDIR_PIN_OE,
  // Input-only pins
  input wire [7:0] INPUT_PIN_IN,
  // Results to the core
  output reg [7:0] BIDIR_READ,
  output reg [7:0] INPUT_READ,
  output reg [7:0] INMODE_STATE,
  output reg ALE,
  output reg [7:0] PAGE_OUT,
  output reg XMEM_BUSY,
  output reg [7:0] XMEM_RDATA,
  output reg ADC_CH0_SEL,
  output reg COUNTER_TWO_INC
);

  localparam ST_IDLE = 2'h0;
  localparam ST_ADDR = 2'h1;
  localparam ST_DATA = 2'h2;

  // ==========================================
  // Registers and internal nets
  reg [7:0] latch_reg;
  reg [7:0] inmode_reg;
  reg [7:0] bidir_s1_reg, bidir_s2_reg;
  reg [7:0] in_s1_reg, in_s2_reg;
  reg t2_prev_reg;
  reg [1:0] state_reg, state_next;
  reg [1:0] cnt_reg, cnt_next;
  reg [23:0] addr_reg;
  reg [7:0] wdata_reg;
  reg wr_reg;
  reg [7:0] pin_out_next, pin_oe_next;
  wire [7:0] in_digital;
  wire t2_fall;

  // ==========================================
  // Shared decodes
  // Requests are taken only from idle; one raised while busy is dropped
  function is_start;
    input [1:0] st;
    input req;
    begin
      is_start = (st == ST_IDLE) && req;
    end
  endfunction

  function is_last;
    input [1:0] count;
    begin
      is_last = (count == `CNT_LAST);
    end
  endfunction

  // ==========================================
  // Pin synchronisers and software state
  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      bidir_s1_reg <= `SYNC_RESET;
      bidir_s2_reg <= `SYNC_RESET;
      in_s1_reg <= `SYNC_RESET;
      in_s2_reg <= `SYNC_RESET;
      latch_reg <= `LATCH_RESET;
      inmode_reg <= `INMODE_RESET;
      // Same level as the synchroniser reset, so release fakes no fall
      t2_prev_reg <= `EDGE_RESET;
    end else if (CLK_EN) begin
      bidir_s1_reg <= BIDIR_PIN_IN;
      bidir_s2_reg <= bidir_s1_reg;
      in_s1_reg <= INPUT_PIN_IN;
      in_s2_reg <= in_s1_reg;
      t2_prev_reg <= in_s2_reg[`COUNT_PIN_BIT];
      if (LATCH_WR)
        latch_reg <= LATCH_WDATA;
      if (INMODE_WR)
        inmode_reg <= INMODE_WDATA;
    end
  end

  // ==========================================
  // Input-only port read path
  // Only the second flop of each synchroniser is read from here on
  genvar g;
  generate
    for (g = 0; g < `PORT_WIDTH; g = g + 1) begin : in_bit_g
      assign in_digital[g] = in_s2_reg[g] & ~inmode_reg[g];
    end
  endgenerate

  // Falling edge on the counter input pin
  assign t2_fall = t2_prev_reg & ~in_s2_reg[`COUNT_PIN_BIT];

  // ==========================================
  // External bus sequencer
  // One address cycle, then data cycles; a read costs the synchroniser
  // delay, traded for a pin path that never reads a metastable flop
  always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      ST_IDLE: begin
        if (is_start(state_reg, XMEM_REQ)) begin
          state_next = ST_ADDR;
          cnt_next = `ALE_CYCLES;
        end
      end
      ST_ADDR: begin
        if (is_last(cnt_reg)) begin
          state_next = ST_DATA;
          cnt_next = `DATA_CYCLES;
        end else begin
          cnt_next = cnt_reg - `CNT_STEP;
        end
      end
      ST_DATA: begin
        if (is_last(cnt_reg))
          state_next = ST_IDLE;
        else
          cnt_next = cnt_reg - `CNT_STEP;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // Pin drive: bus drives both levels, port mode only pulls low
  // Address comes straight from the request so it meets the strobe
  always @* begin
    case (state_next)
      ST_ADDR: begin
        pin_out_next = is_start(state_reg, XMEM_REQ) ?
          XMEM_ADDR[`LOW_BYTE_LSB +: 8] : addr_reg[`LOW_BYTE_LSB +: 8];
        pin_oe_next = `DRIVE_ALL;
      end
      ST_DATA: begin
        pin_out_next = wdata_reg;
        pin_oe_next = wr_reg ? `DRIVE_ALL : `DRIVE_NONE;
      end
      default: begin
        pin_out_next = `BYTE_CLEAR;
        pin_oe_next = ~latch_reg;
      end
    endcase
  end

  // ==========================================
  // Output registers
  always @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= ST_IDLE;
      cnt_reg <= `CNT_CLEAR;
      addr_reg <= `ADDR_CLEAR;
      wdata_reg <= `BYTE_CLEAR;
      wr_reg <= `FLAG_CLEAR;
      BIDIR_PIN_OUT <= `BYTE_CLEAR;
      BIDIR_PIN_OE <= `DRIVE_NONE;
      ALE <= `FLAG_CLEAR;
      PAGE_OUT <= `BYTE_CLEAR;
      XMEM_BUSY <= `FLAG_CLEAR;
      XMEM_RDATA <= `BYTE_CLEAR;
      BIDIR_READ <= `BYTE_CLEAR;
      INPUT_READ <= `BYTE_CLEAR;
      INMODE_STATE <= `INMODE_RESET;
      ADC_CH0_SEL <= `FLAG_CLEAR;
      COUNTER_TWO_INC <= `FLAG_CLEAR;
    end else if (CLK_EN) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      if (is_start(state_reg, XMEM_REQ)) begin
        addr_reg <= XMEM_ADDR;
        wdata_reg <= XMEM_WDATA;
        wr_reg <= XMEM_WRITE;
        PAGE_OUT <= XMEM_ADDR[`PAGE_BYTE_LSB +: 8];
      end
      BIDIR_PIN_OUT <= pin_out_next;
      BIDIR_PIN_OE <= pin_oe_next;
      ALE <= (state_next == ST_ADDR);
      XMEM_BUSY <= (state_next != ST_IDLE);
      // Sample shows the pins two edges earlier, well inside the data phase
      if (state_reg == ST_DATA && is_last(cnt_reg) && !wr_reg)
        XMEM_RDATA <= bidir_s2_reg;
      BIDIR_READ <= bidir_s2_reg;
      // No drive exists for this port, only a read path
      INPUT_READ <= in_digital;
      INMODE_STATE <= inmode_reg;
      ADC_CH0_SEL <= (ADC_CHSEL == `CHSEL_ZERO);
      COUNTER_TWO_INC <= CNT_EXT_EN & t2_fall;
    end
  end

endmodule // port_pin_logic

/* File: test/port_mem_model.sv */
// Far side of the multiplexed port: board pull-ups and a data memory.
// Assumes the block's pin enables, pin values and bus strobes.
`timescale 1ns/1ps
module port_mem_model (
  input wire clk,
  input wire [7:0] oe,
  input wire [7:0] out,
  input wire ale,
  input wire busy,
  input wire [7:0] pull_low,
  output wire [7:0] pin
);
  reg [7:0] mem [0:255];
  reg [7:0] addr_reg;
  // Memory answers only in the read data phase, else pull-ups win
  wire rd_phase = busy & ~ale & ~|oe;
  wire [7:0] ext = rd_phase ? mem[addr_reg] : ~pull_low;
  assign pin = oe & out | ~oe & ext;
  always @(posedge clk) begin
    if (ale)
      addr_reg <= pin;
    else if (busy & &oe)
      mem[addr_reg] <= pin;
  end
endmodule // port_mem_model

/* File: test/port_pin_chk.sv */
// Assertions on the pin logic ports.
// Assumes only the top ports; checks pause while CLK_EN is low.
`timescale 1ns/1ps
module port_pin_chk (
  // Watched ports
  input wire MCLK,
  input wire RESET_N,
  input wire CLK_EN,
  input wire [2:0] ADC_CHSEL,
  input wire CNT_EXT_EN,
  input wire [7:0] INPUT_PIN_IN,
  input wire [7:0] BIDIR_PIN_OUT,
  input wire [7:0] BIDIR_PIN_OE,
  input wire [7:0] INPUT_READ,
  input wire [7:0] INMODE_STATE,
  input wire ALE,
  input wire XMEM_BUSY,
  input wire ADC_CH0_SEL,
  input wire COUNTER_TWO_INC
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESET_N || !CLK_EN);
  sequence addr_sq; ALE && XMEM_BUSY; endsequence
  sequence data_sq; XMEM_BUSY [*3] ##1 !XMEM_BUSY; endsequence
  od_low_a: assert property (!XMEM_BUSY |-> BIDIR_PIN_OUT == 8'h00)
    else $error("port drives high");
  ale_one_a: assert property (ALE |=> !ALE)
    else $error("strobe too long");
  addr_drive_a: assert property (ALE |-> XMEM_BUSY && &BIDIR_PIN_OE)
    else $error("address not driven");
  busy_len_a: assert property ($rose(XMEM_BUSY) |-> addr_sq ##1 data_sq)
    else $error("access length wrong");
  data_drive_a: assert property (
    XMEM_BUSY && !ALE |-> BIDIR_PIN_OE == 8'hFF || BIDIR_PIN_OE == 8'h00)
    else $error("data phase drive mixed");
  chan_zero_a: assert property (
    1'b1 |=> ADC_CH0_SEL == ($past(ADC_CHSEL) == 3'h0))
    else $error("channel flag wrong");
  inc_once_a: assert property (COUNTER_TWO_INC |=> !COUNTER_TWO_INC)
    else $error("count pulse too long");
  inc_cause_a: assert property (
    $fell(INPUT_PIN_IN[0]) && CNT_EXT_EN |-> ##[2:5] COUNTER_TWO_INC)
    else $error("edge not counted");
  analog_zero_a: assert property (
    (INPUT_READ & INMODE_STATE & $past(INMODE_STATE)) == 8'h00)
    else $error("analog bit read high");
endmodule // port_pin_chk
bind port_pin_logic port_pin_chk port_pin_chk_i(.*);

/* File: test/testbench.sv */
// Bench for the pin logic: latch, bus, input port and counter tests.
// Assumes the far-side model and the bound checker.
`timescale 1ns/1ps
module testbench;
  reg clk = 0, rst_n = 0, lw = 0, mw = 0, rq = 0, wr = 0, en = 0, ce = 1;
  reg [7:0] ld = 8'h00, md = 8'h00, wd = 8'h00, ip = 8'hFF, pl = 8'h00;
  reg [23:0] ad = 24'h000000;
  reg [2:0] cs = 3'h1;
  wire [7:0] po, oe, pin, br, ir, ms, pg, rd;
  wire ale, bsy, ch0, inc;
  integer n_mismatch = 0, num_checks = 0, i, k;
  always #25 clk = ~clk;
  port_pin_logic port_pin_logic_i(.MCLK(clk), .RESET_N(rst_n),
    .CLK_EN(ce), .LATCH_WR(lw), .LATCH_WDATA(ld), .INMODE_WR(mw),
    .INMODE_WDATA(md), .XMEM_REQ(rq), .XMEM_WRITE(wr), .XMEM_ADDR(ad),
    .XMEM_WDATA(wd), .ADC_CHSEL(cs), .CNT_EXT_EN(en), .BIDIR_PIN_IN(pin),
    .BIDIR_PIN_OUT(po), .BIDIR_PIN_OE(oe), .INPUT_PIN_IN(ip),
    .BIDIR_READ(br), .INPUT_READ(ir), .INMODE_STATE(ms), .ALE(ale),
    .PAGE_OUT(pg), .XMEM_BUSY(bsy), .XMEM_RDATA(rd), .ADC_CH0_SEL(ch0),
    .COUNTER_TWO_INC(inc));
  port_mem_model port_mem_model_i(.clk(clk), .oe(oe), .out(po),
    .ale(ale), .busy(bsy), .pull_low(pl), .pin(pin));
  // ====
  // Shared tasks
  task chk(input [7:0] a, input [7:0] e);
    begin
      num_checks = num_checks + 1;
      if (a !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0t got %h exp %h", $time, a, e);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge clk);
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // ====
  // Tests
  task t_latch;
    begin
      ld = 8'hA5; lw = 1; cyc(1); lw = 0; cyc(2);
      chk(oe, 8'h5A);
      chk(po, 8'h00);
      pl = 8'h0F; cyc(4);
      chk(br, 8'hA0);
      $display("latch test done");
    end
  endtask
  task t_freeze;
    begin
      ce = 0; ld = 8'h0F; lw = 1; cyc(2); lw = 0;
      chk(oe, 8'h5A);
      ce = 1; cyc(2);
      chk(oe, 8'h5A);
      $display("freeze test done");
    end
  endtask
  task t_bus;
    begin
      ad = 24'hC30096; wd = 8'h3C; wr = 1; rq = 1; cyc(1); rq = 0;
      chk({ale, bsy}, 8'h03);
      chk(po, 8'h96);
      chk(pg, 8'hC3);
      cyc(1); chk(po, 8'h3C);
      chk(oe, 8'hFF);
      cyc(2); chk({ale, bsy}, 8'h01);
      cyc(1); chk({ale, bsy}, 8'h00);
      wr = 0; rq = 1; cyc(1); rq = 0; cyc(1);
      chk(oe, 8'h00);
      cyc(3); chk(rd, 8'h3C);
      $display("bus test done");
    end
  endtask
  task fall_count(input e, input [7:0] n_exp);
    begin
      en = e; ip = 8'h01; cyc(4); ip = 8'h00; k = 0;
      repeat (8) begin cyc(1); k = k + inc; end
      chk(k[7:0], n_exp);
    end
  endtask
  task t_in;
    begin
      chk(ms, 8'hFF);
      chk(ir, 8'h00);
      ip = 8'h5A; md = 8'h0E; mw = 1; cyc(1); mw = 0; cyc(4);
      chk(ms, 8'h0E);
      chk(ir, 8'h50);
      for (i = 0; i < 8; i = i + 1) begin
        cs = i[2:0]; cyc(2); chk(ch0, i == 0);
      end
      fall_count(1'b1, 8'h01);
      fall_count(1'b0, 8'h00);
      $display("input test done");
    end
  endtask
  initial begin
    cyc(3); rst_n = 1; cyc(1);
    t_latch; t_freeze; t_bus; t_in;
    end_sim;
  end
  initial begin
    #20000 n_mismatch = n_mismatch + 1;
    end_sim;
  end
endmodule // testbench
